// >>> rtl/nand_irq_pkg.sv
// Constants and carrier types for the NAND controller interrupt block.
// Assumes a single 40 MHz system clock and a 32-bit AXI4-Lite bus.
package nand_irq_pkg;

    // Register byte addresses
    localparam logic [31:0] OFS_EDGE_MODE        = 32'h400e_0000;
    localparam logic [31:0] OFS_STATUS           = 32'h400e_0008;
    localparam logic [31:0] OFS_IRQ_ENABLE       = 32'h400e_000c;
    localparam logic [31:0] OFS_IRQ_DISABLE      = 32'h400e_0010;
    localparam logic [31:0] OFS_IRQ_MASK         = 32'h400e_0014;
    localparam logic [31:0] OFS_FIRST_ADDR_CYCLE = 32'h400e_0018;
    localparam logic [31:0] OFS_BANK_NUMBER      = 32'h400e_001c;

    // Source bit positions, shared by status, enable, disable and mask
    localparam int BIT_RDY_RISING_EDGE       = 4;
    localparam int BIT_RDY_FALLING_EDGE      = 5;
    localparam int BIT_TRANSFER_FINISHED     = 16;
    localparam int BIT_COMMAND_FINISHED      = 17;
    localparam int BIT_DATA_TIMEOUT_ERROR    = 20;
    localparam int BIT_UNDEFINED_AREA_ACCESS = 21;
    localparam int BIT_ACCESS_WHILE_BUSY     = 22;
    localparam int BIT_ACCESS_SIZE_ERROR     = 23;
    localparam int BIT_LINE0_EDGE_EVENT      = 24;

    // Defined sources; every other bit is reserved
    localparam logic [31:0] SOURCE_BITS = 32'h01f3_0030;

    // Field layouts and reset values
    localparam int BANK_W       = 3;
    localparam int ADDR_BYTE_W  = 8;
    localparam int BIT_EDGE_SEL = 0;
    localparam logic [31:0]          RST_MASK      = 32'h0000_0000;
    localparam logic [31:0]          RST_FLAGS     = 32'h0000_0000;
    localparam logic [ADDR_BYTE_W-1:0] RST_ADDR_BYTE = 8'h00;
    localparam logic [BANK_W-1:0]    RST_BANK      = 3'h0;

    // Access size encoding of the memory-area access port
    localparam logic [1:0] SIZE_WORD = 2'h2;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // One-cycle event pulses from the controller core
    typedef struct packed {
        logic transfer_finished;
        logic command_finished;
        logic data_timeout_error;
        logic undefined_area_access;
        logic access_while_busy;
    } nfc_events_t;

endpackage : nand_irq_pkg

// >>> rtl/nand_ctrl_irq_enable_mask.sv
// Interrupt enable, disable and mask logic of the NAND flash controller,
// with the first-address-cycle and bank registers, as an AXI4-Lite slave.
// Assumes event pulses and the ready/busy line are synchronous to aclk.
//
// Register access over AXI4-Lite is this design's own decision.
module nand_ctrl_irq_enable_mask
    import nand_irq_pkg::*;
(
    // Clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // AXI4-Lite write address and data
    input  wire logic [31:0]            awaddr,
    input  wire logic [2:0]             awprot,
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,
    // AXI4-Lite write response
    output logic [1:0]                  bresp,
    output logic                        bvalid,
    input  wire logic                   bready,
    // AXI4-Lite read
    input  wire logic [31:0]            araddr,
    input  wire logic [2:0]             arprot,
    input  wire logic                   arvalid,
    output logic                        arready,
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output logic                        rvalid,
    input  wire logic                   rready,
    // Controller events
    input  wire nfc_events_t            events,
    input  wire logic                   rdy_line,
    input  wire logic                   mem_access_valid,
    input  wire logic [1:0]             mem_access_size,
    // Outputs to the controller and system
    output logic [ADDR_BYTE_W-1:0]      first_address_byte,
    output logic [BANK_W-1:0]           flash_bank_number,
    output logic                        irq
);

    typedef struct packed {
        logic                   awready;
        logic                   wready;
        logic                   aw_got;
        logic                   w_got;
        logic [31:0]            waddr;
        logic [31:0]            wdat;
        logic [3:0]             wstb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arready;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
        logic [31:0]            mask;
        logic [31:0]            flags;
        logic [ADDR_BYTE_W-1:0] addr_byte;
        logic [BANK_W-1:0]      bank;
        logic                   edge_fall;
        logic                   rdy_prev;
        logic                   irq;
    } state_t;

    state_t s;
    state_t next_s;

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = data[8*i +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    logic        do_write;
    logic        do_read;
    logic        status_read;
    logic [31:0] wbits;
    logic [31:0] ev_bits;
    logic        rise;
    logic        fall;

    assign do_write    = s.aw_got && s.w_got && !s.bvalid;
    assign do_read     = arvalid && s.arready;
    assign status_read = do_read && (araddr == OFS_STATUS);
    assign wbits       = lane_merge(32'h0000_0000, s.wdat, s.wstb)
                         & SOURCE_BITS;
    assign rise        = rdy_line && !s.rdy_prev;
    assign fall        = !rdy_line && s.rdy_prev;

    always_comb begin
        ev_bits = 32'h0000_0000;
        ev_bits[BIT_RDY_RISING_EDGE]       = rise;
        ev_bits[BIT_RDY_FALLING_EDGE]      = fall;
        ev_bits[BIT_TRANSFER_FINISHED]     = events.transfer_finished;
        ev_bits[BIT_COMMAND_FINISHED]      = events.command_finished;
        ev_bits[BIT_DATA_TIMEOUT_ERROR]    = events.data_timeout_error;
        ev_bits[BIT_UNDEFINED_AREA_ACCESS] = events.undefined_area_access;
        ev_bits[BIT_ACCESS_WHILE_BUSY]     = events.access_while_busy;
        ev_bits[BIT_ACCESS_SIZE_ERROR]     = mem_access_valid
                                             && (mem_access_size != SIZE_WORD);
        ev_bits[BIT_LINE0_EDGE_EVENT]      = s.edge_fall ? fall : rise;
    end

    always_comb begin
        next_s          = s;
        next_s.rdy_prev = rdy_line;

        // Write channel: address and data taken in either order
        if (awvalid && s.awready) begin
            next_s.aw_got = 1'b1;
            next_s.waddr  = awaddr;
        end
        if (wvalid && s.wready) begin
            next_s.w_got = 1'b1;
            next_s.wdat  = wdata;
            next_s.wstb  = wstrb;
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (do_write) begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = RESP_OKAY;
            unique case (s.waddr)
                OFS_IRQ_ENABLE: begin
                    next_s.mask = s.mask | wbits;
                end
                OFS_IRQ_DISABLE: begin
                    next_s.mask = s.mask & ~wbits;
                end
                OFS_STATUS: begin
                    next_s.flags = s.flags & ~wbits;
                end
                OFS_FIRST_ADDR_CYCLE: begin
                    next_s.addr_byte = ADDR_BYTE_W'(lane_merge(
                        {24'h00_0000, s.addr_byte}, s.wdat,
                        s.wstb));
                end
                OFS_BANK_NUMBER: begin
                    next_s.bank = BANK_W'(lane_merge(
                        {29'h0000_0000, s.bank}, s.wdat,
                        s.wstb));
                end
                OFS_EDGE_MODE: begin
                    if (s.wstb[0]) begin
                        next_s.edge_fall = s.wdat[BIT_EDGE_SEL];
                    end
                end
                OFS_IRQ_MASK: begin
                    next_s.bresp = RESP_OKAY;
                end
                default: begin
                    next_s.bresp = RESP_DECERR;
                end
            endcase
        end

        // Read channel
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (do_read) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = RESP_OKAY;
            next_s.rdata  = 32'h0000_0000;
            unique case (araddr)
                OFS_STATUS: begin
                    next_s.rdata = s.flags;
                end
                OFS_IRQ_MASK: begin
                    next_s.rdata = s.mask;
                end
                OFS_FIRST_ADDR_CYCLE: begin
                    next_s.rdata = {24'h00_0000, s.addr_byte};
                end
                OFS_BANK_NUMBER: begin
                    next_s.rdata = {29'h0000_0000, s.bank};
                end
                OFS_EDGE_MODE: begin
                    next_s.rdata = {31'h0000_0000, s.edge_fall};
                end
                OFS_IRQ_ENABLE, OFS_IRQ_DISABLE: begin
                    next_s.rdata = 32'h0000_0000;
                end
                default: begin
                    next_s.rresp = RESP_DECERR;
                end
            endcase
        end

        // status read clears, new events win
        if (status_read) begin
            next_s.flags = 32'h0000_0000;
        end
        next_s.flags = next_s.flags | ev_bits;

        next_s.irq = |(next_s.flags & next_s.mask);

        // Each ready only while its own beat is not held and no response is pending, so one write and one read at a time
        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready  = !next_s.w_got && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s           <= '0;
            s.mask      <= RST_MASK;
            s.flags     <= RST_FLAGS;
            s.addr_byte <= RST_ADDR_BYTE;
            s.bank      <= RST_BANK;
        end else begin
            s <= next_s;
        end
    end

    assign awready            = s.awready;
    assign wready             = s.wready;
    assign bvalid             = s.bvalid;
    assign bresp              = s.bresp;
    assign arready            = s.arready;
    assign rvalid             = s.rvalid;
    assign rdata              = s.rdata;
    assign rresp              = s.rresp;
    assign first_address_byte = s.addr_byte;
    assign flash_bank_number  = s.bank;
    assign irq                = s.irq;

    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic wr_ier;
    logic wr_idr;
    assign wr_ier = do_write && (s.waddr == OFS_IRQ_ENABLE);
    assign wr_idr = do_write && (s.waddr == OFS_IRQ_DISABLE);

    sequence mask_read_issued;
        do_read && (araddr == OFS_IRQ_MASK);
    endsequence

    a_enable_sets: assert property (
        wr_ier |=> ((s.mask & $past(wbits)) == $past(wbits))
                   && ((s.mask | $past(s.mask)) == s.mask))
        else $error("enable write did not set mask bits");

    a_disable_clears: assert property (
        wr_idr |=> ((s.mask & $past(wbits)) == 32'h0000_0000)
                   && ((s.mask & ~$past(s.mask)) == 32'h0000_0000))
        else $error("disable write did not clear mask bits");

    a_mask_readback: assert property (
        mask_read_issued ##1 1'b1 |-> rvalid
                   && (rdata == ($past(s.mask) & SOURCE_BITS)))
        else $error("mask read data wrong");

    a_rise_bits: assert property (
        (rdy_line && !s.rdy_prev) |=> s.flags[BIT_RDY_RISING_EDGE]
            && (!s.flags[BIT_RDY_FALLING_EDGE]
                || $past(s.flags[BIT_RDY_FALLING_EDGE])))
        else $error("rising edge not at bit 4");

    a_done_bits: assert property (
        events.command_finished |=> s.flags[BIT_COMMAND_FINISHED])
        else $error("command finished not at bit 17");

    a_size_error: assert property (
        (mem_access_valid && mem_access_size != SIZE_WORD)
            |=> s.flags[BIT_ACCESS_SIZE_ERROR])
        else $error("access size error not flagged");

    a_disable_reads_zero: assert property (
        (do_read && araddr == OFS_IRQ_DISABLE) |=> rdata == 32'h0000_0000)
        else $error("disable register read not zero");

    a_addr_byte_write: assert property (
        (do_write && s.waddr == OFS_FIRST_ADDR_CYCLE && s.wstb[0])
            |=> first_address_byte == $past(s.wdat[7:0]))
        else $error("first address byte not stored");

    a_status_clears: assert property (
        // An event in the read cycle itself survives, so exclude it
        (status_read && (ev_bits == 32'h0000_0000))
            |=> s.flags == 32'h0000_0000)
        else $error("status read did not clear flags");

    a_line_edge: assert property (
        (s.edge_fall && rise && !fall) |=> !s.flags[BIT_LINE0_EDGE_EVENT]
            || $past(s.flags[BIT_LINE0_EDGE_EVENT]))
        else $error("line edge took the unselected edge");

    a_irq_follows: assert property (
        ##1 irq == |(s.flags & s.mask))
        else $error("interrupt does not match flags and mask");

    // A disable in the same cycle may legally suppress the interrupt
    a_irq_on_event: assert property (
        (((ev_bits & s.mask) != 32'h0000_0000) && !wr_idr) |=> irq)
        else $error("enabled event did not raise interrupt");

    a_mask_after_reset: assert property (
        $rose(aresetn) |-> (s.mask == 32'h0000_0000) && !irq)
        else $error("mask or interrupt not clear after reset");

endmodule : nand_ctrl_irq_enable_mask

// >>> test/testbench.sv
// Self-checking bench for the NAND controller interrupt enable/mask block.
// Assumes the AXI4-Lite slave answers in its own time; waits are bounded.
module testbench import nand_irq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    nfc_events_t events = '0;
    logic        rdy_line = 1'b0, mem_access_valid = 1'b0;
    logic [1:0]  mem_access_size = SIZE_WORD;
    logic [ADDR_BYTE_W-1:0] first_address_byte;
    logic [BANK_W-1:0]      flash_bank_number;
    int err_count = 0, n_tests = 0, cycles = 0;

    always #12.5 aclk = ~aclk;

    nand_ctrl_irq_enable_mask u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .events(events), .rdy_line(rdy_line),
        .mem_access_valid(mem_access_valid),
        .mem_access_size(mem_access_size),
        .first_address_byte(first_address_byte),
        .flash_bank_number(flash_bank_number), .irq(irq));

    task automatic final_report;
        $display("Checks %0d, errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    // A hung handshake ends the run here rather than stalling forever
    always @(posedge aclk) begin
        cycles++;
        if (cycles > 20000) begin
            err_count++;
            final_report();
        end
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask : check

    task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
                             input logic [1:0] exp_resp);
        bit aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && awready) begin
                aw_done = 1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready) begin
                w_done = 1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 1'b0;
        check("bresp", {30'h0, exp_resp}, {30'h0, bresp});
    endtask : axi_write

    task automatic axi_read(input logic [31:0] a, input logic [31:0] exp,
                            input logic [1:0] exp_resp);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rready <= 1'b0;
        check("rresp", {30'h0, exp_resp}, {30'h0, rresp});
        check("rdata", exp, rdata);
    endtask : axi_read

    // Fire one source event for k 1 to 8, two for k 0 and 9 (ready edge plus line 0 edge), a word-size access with no event for other k; k picks the stimulus
    task automatic fire(input int k);
        @(posedge aclk);
        case (k)
            0, 8: rdy_line <= 1'b1;
            1, 9: rdy_line <= 1'b0;
            2: events.transfer_finished <= 1'b1;
            3: events.command_finished <= 1'b1;
            4: events.data_timeout_error <= 1'b1;
            5: events.undefined_area_access <= 1'b1;
            6: events.access_while_busy <= 1'b1;
            7: begin
                mem_access_valid <= 1'b1;
                mem_access_size  <= 2'h0;
            end
            default: mem_access_valid <= 1'b1;
        endcase
        @(posedge aclk);
        events           <= '0;
        mem_access_valid <= 1'b0;
        mem_access_size  <= SIZE_WORD;
        repeat (3) @(posedge aclk);
    endtask : fire

    task automatic test_reset_values;
        check("irq after reset", 32'h0, {31'h0, irq});
        axi_read(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
        axi_read(OFS_IRQ_DISABLE, 32'h0, RESP_OKAY);
        axi_read(OFS_FIRST_ADDR_CYCLE, 32'h0, RESP_OKAY);
        axi_read(OFS_BANK_NUMBER, 32'h0, RESP_OKAY);
    endtask : test_reset_values

    task automatic test_enable_disable;
        logic [31:0] m;
        axi_write(OFS_IRQ_ENABLE, 32'hffff_ffff, RESP_OKAY);
        axi_read(OFS_IRQ_MASK, SOURCE_BITS, RESP_OKAY);
        axi_write(OFS_IRQ_ENABLE, 32'h0, RESP_OKAY);
        axi_read(OFS_IRQ_MASK, SOURCE_BITS, RESP_OKAY);
        axi_write(OFS_IRQ_DISABLE, 32'h0080_0010, RESP_OKAY);
        m = SOURCE_BITS & ~32'h0080_0010;
        axi_read(OFS_IRQ_MASK, m, RESP_OKAY);
        axi_write(OFS_IRQ_DISABLE, 32'h0, RESP_OKAY);
        axi_read(OFS_IRQ_MASK, m, RESP_OKAY);
        axi_read(OFS_IRQ_DISABLE, 32'h0, RESP_OKAY);
        // Mask is read-only; a write must leave it alone
        axi_write(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
        axi_read(OFS_IRQ_MASK, m, RESP_OKAY);
        axi_write(OFS_IRQ_DISABLE, 32'hffff_ffff, RESP_OKAY);
        axi_read(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
    endtask : test_enable_disable

    task automatic test_sources;
        logic [31:0] exp_st [10];
        logic [31:0] en [10];
        exp_st = '{32'h0100_0010, 32'h0000_0020, 32'h0001_0000,
                   32'h0002_0000, 32'h0010_0000, 32'h0020_0000,
                   32'h0040_0000, 32'h0080_0000, 32'h0000_0010,
                   32'h0100_0020};
        en = '{32'h10, 32'h20, 32'h1_0000, 32'h2_0000, 32'h10_0000,
               32'h20_0000, 32'h40_0000, 32'h80_0000, 32'h10,
               32'h0100_0000};
        axi_read(OFS_STATUS, 32'h0, RESP_OKAY);
        for (int k = 0; k < 10; k++) begin
            if (k == 8) begin
                axi_write(OFS_EDGE_MODE, 32'h1, RESP_OKAY);
            end
            axi_write(OFS_IRQ_ENABLE, en[k], RESP_OKAY);
            fire(k);
            check("irq on event", 32'h1, {31'h0, irq});
            axi_read(OFS_STATUS, exp_st[k], RESP_OKAY);
            axi_read(OFS_STATUS, 32'h0, RESP_OKAY);
            check("irq after clear", 32'h0, {31'h0, irq});
            axi_write(OFS_IRQ_DISABLE, en[k], RESP_OKAY);
        end
        axi_write(OFS_EDGE_MODE, 32'h0, RESP_OKAY);
        // Masked event: flag recorded, no interrupt
        fire(2);
        check("irq masked", 32'h0, {31'h0, irq});
        fire(10);
        axi_read(OFS_STATUS, 32'h0001_0000, RESP_OKAY);
    endtask : test_sources

    task automatic test_data_regs;
        logic [31:0] bmax;
        bmax = (32'h1 << BANK_W) - 32'h1;
        axi_write(OFS_FIRST_ADDR_CYCLE, 32'hdead_be5a, RESP_OKAY);
        axi_read(OFS_FIRST_ADDR_CYCLE, 32'h5a, RESP_OKAY);
        check("addr byte out", 32'h5a, {24'h0, first_address_byte});
        axi_write(OFS_BANK_NUMBER, 32'hffff_ffff, RESP_OKAY);
        axi_read(OFS_BANK_NUMBER, bmax, RESP_OKAY);
        check("bank out", bmax, 32'(flash_bank_number));
        axi_write(32'h400e_0100, 32'h1, RESP_DECERR);
        axi_read(32'h400e_0100, 32'h0, RESP_DECERR);
        axi_read(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
    endtask : test_data_regs

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        test_reset_values();
        test_enable_disable();
        test_sources();
        test_data_regs();
        final_report();
    end

endmodule : testbench
